/* File: core/cmr_regs.vh */
// register indices, field positions, reset values and exception numbers
// assumes a plain strobe register port, one word per index
`ifndef CMR_REGS_VH
`define CMR_REGS_VH
`define CMR_IDX_W 5
// core register indices (general registers 0..12 share the memory)
`define CMR_IDX_SP 5'h0D
`define CMR_IDX_LR 5'h0E
`define CMR_IDX_PC 5'h0F
`define CMR_IDX_PSR 5'h10
`define CMR_IDX_APPLICATION_STATUS 5'h11
`define CMR_IDX_INTERRUPT_STATUS 5'h12
`define CMR_IDX_EXECUTION_STATUS 5'h13
`define CMR_IDX_PRIM 5'h14
`define CMR_IDX_FLTM 5'h15
`define CMR_IDX_BPRI 5'h16
`define CMR_IDX_MODE 5'h17
`define CMR_IDX_MSP 5'h18
`define CMR_IDX_PSP 5'h19
`define CMR_IDX_STAT 5'h1A
// field layout of the program status word
`define CMR_APPLICATION_STATUS_MASK 32'hF8000000
`define CMR_INTERRUPT_STATUS_MASK 32'h000001FF
`define CMR_EXECUTION_STATUS_MASK 32'h0600FC00
`define CMR_CIS_BIT 24
`define CMR_EXC_W 9
// mode control bits
`define CMR_MODE_USER 0
`define CMR_MODE_ALT 1
// exception numbers
`define CMR_EXC_NMI 9'h002
`define CMR_EXC_HARD 9'h003
// reset values
`define CMR_RST_WORD 32'h00000000
`define CMR_RST_EXECUTION_STATUS 32'h01000000
`define CMR_RST_MODE 2'h0
`endif

/* File: core/cmr_gpr_mem.v */
// general register storage, registered read port
// assumes one clock; index checked by the caller
`timescale 1ns/1ps
module cmr_gpr_mem #(
   parameter WIDTH = 32,
   parameter DEPTH = 13,
   parameter AW = 4
) (
   input wire ref_clk,
   input wire wrEn,
   input wire [AW-1:0] wrAddr,
   input wire [WIDTH-1:0] wrData,
   input wire [AW-1:0] rdAddr,
   output reg [WIDTH-1:0] rdData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   always @(posedge ref_clk) begin
      if (wrEn)
         mem[wrAddr] <= wrData;
      rdData <= mem[rdAddr];
   end
endmodule // cmr_gpr_mem

/* File: core/cmr_core_regs.v */
// core mode state and architectural register file
// assumes a single-cycle strobe register port and an execution unit on ref_clk
`timescale 1ns/1ps
`include "cmr_regs.vh"
// Functional notes
// RQ1: three states; handler only when privileged
// RQ2: user access to special registers faults
// RQ3: handler while servicing exception, else thread
// RQ4: sixteen core registers, 32 bits each
// RQ5: high registers need wide instruction form
// RQ6: process stack only user thread mode
// RQ7: stack pointer low two bits zero
// RQ8: call writes return address to link
// RQ9: program counter bit zero ignored
// RQ10: status word accessed jointly or separately
// RQ11: result flags in top five bits
// RQ12: exception number in low nine bits
// RQ13: continuation and block bits two ranges
// RQ14: compact state bit reads one; clear faults
// RQ15: primary mask passes only nmi, hard fault
// RQ16: fault mask passes only nmi
// RQ17: base priority masks equal or higher; zero off
// RQ18: mode bit zero selects user thread
// RQ19: mode bit one selects process stack
// RQ20: reset input active low, pulled high
// RQ21: ignored low bits read back zero
module cmr_core_regs #(
   parameter PRIO_W = 9
) (
   input wire ref_clk,
   input wire nrst,
   input wire [4:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   input wire regRd,
   input wire narrowInsn,
   input wire callValid,
   input wire [31:0] callReturnAddr,
   input wire flagsValid,
   input wire [4:0] flagsIn,
   input wire excEnter,
   input wire [8:0] excNum,
   input wire excReturn,
   input wire irqReq,
   input wire [8:0] irqNum,
   input wire [PRIO_W-1:0] irqPrio,
   output reg [31:0] regRdData,
   output reg faultPulse,
   output reg handlerMode,
   output reg privileged,
   output reg irqTaken
);
   // architectural state
   reg [31:0] msp_r;
   reg [31:0] psp_r;
   reg [31:0] lr_r;
   reg [31:0] pc_r;
   reg [31:0] application_status_r;
   reg [31:0] execution_status_r;
   reg [8:0] interrupt_status_r;
   reg prim_r;
   reg fltm_r;
   reg [PRIO_W-1:0] bpri_r;
   reg [1:0] mode_r;

   // read pipeline, two deep
   reg rdGpr_r;
   reg [31:0] rdHold_r;

   // next values
   reg [31:0] msp_nxt;
   reg [31:0] psp_nxt;
   reg [31:0] lr_nxt;
   reg [31:0] pc_nxt;
   reg [31:0] application_status_nxt;
   reg [31:0] execution_status_nxt;
   reg [8:0] interrupt_status_nxt;
   reg prim_nxt;
   reg fltm_nxt;
   reg [PRIO_W-1:0] bpri_nxt;
   reg [1:0] mode_nxt;
   reg rdGpr_nxt;
   reg [31:0] rdHold_nxt;
   reg [31:0] regRdData_nxt;
   reg faultPulse_nxt;
   reg handlerMode_nxt;
   reg privileged_nxt;
   reg irqTaken_nxt;

   wire [31:0] gprRd;
   wire inHandler = (interrupt_status_r != 9'h000);
   // RQ1 user only outside handler
   wire userLvl = mode_r[`CMR_MODE_USER] & ~inHandler;
   // RQ6 process stack selection
   wire usePsp = userLvl & mode_r[`CMR_MODE_ALT];
   wire [31:0] spCur = usePsp ? psp_r : msp_r;
   wire isGpr = (regAddr < 5'h0D);
   // RQ5 high registers refused to narrow form
   wire gprBad = narrowInsn & regAddr[3];
   // RQ2 user blocked from special registers
   wire special = (regAddr >= `CMR_IDX_PSR) && (regAddr != `CMR_IDX_APPLICATION_STATUS);
   wire userBad = userLvl & special & (regWr | regRd);
   // RQ14 clearing compact state faults
   wire epsrWr = regWr & ((regAddr == `CMR_IDX_PSR) | (regAddr == `CMR_IDX_EXECUTION_STATUS));
   wire cisBad = epsrWr & ~regWrData[`CMR_CIS_BIT];
   wire unmapped = (regAddr > `CMR_IDX_STAT);
   wire wrOk = regWr & ~userBad & ~cisBad & ~(isGpr & gprBad) & ~unmapped;
   // RQ7 aligned stack write
   wire [31:0] spWr = {regWrData[31:2], 2'b00};
   // RQ15 RQ16 RQ17 exception gating
   wire isNmi = (irqNum == `CMR_EXC_NMI);
   wire isHard = (irqNum == `CMR_EXC_HARD);
   wire bpriBlk = (bpri_r != {PRIO_W{1'b0}}) && (irqPrio >= bpri_r);
   wire gateOk = isNmi | (~fltm_r & (isHard | (~prim_r & ~bpriBlk)));

   // RQ4 thirteen 32-bit general registers
   cmr_gpr_mem #(
      .WIDTH(32),
      .DEPTH(13),
      .AW(4)
   ) cmr_gpr_mem_i (
      .ref_clk(ref_clk),
      .wrEn(wrOk & isGpr),
      .wrAddr(regAddr[3:0]),
      .wrData(regWrData),
      .rdAddr(regAddr[3:0]),
      .rdData(gprRd)
   );
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h00000000;
      case (regAddr)
         // RQ21 RQ7 stack pointer reads aligned
         `CMR_IDX_SP: rdMux = {spCur[31:2], 2'b00};
         `CMR_IDX_LR: rdMux = lr_r;
         // RQ21 RQ9 program counter reads aligned
         `CMR_IDX_PC: rdMux = {pc_r[31:1], 1'b0};
         // RQ10 joint and separate views
         `CMR_IDX_PSR: rdMux = application_status_r | execution_status_r | {23'h000000, interrupt_status_r};
         `CMR_IDX_APPLICATION_STATUS: rdMux = application_status_r;
         `CMR_IDX_INTERRUPT_STATUS: rdMux = {23'h000000, interrupt_status_r};
         `CMR_IDX_EXECUTION_STATUS: rdMux = execution_status_r;
         `CMR_IDX_PRIM: rdMux = {31'h00000000, prim_r};
         `CMR_IDX_FLTM: rdMux = {31'h00000000, fltm_r};
         `CMR_IDX_BPRI: rdMux = {{(32-PRIO_W){1'b0}}, bpri_r};
         `CMR_IDX_MODE: rdMux = {30'h00000000, mode_r};
         `CMR_IDX_MSP: rdMux = {msp_r[31:2], 2'b00};
         `CMR_IDX_PSP: rdMux = {psp_r[31:2], 2'b00};
         `CMR_IDX_STAT: rdMux = {29'h00000000, usePsp, userLvl, inHandler};
         default: rdMux = 32'h00000000;
      endcase
   end

   // qualified write strobes, one per writable non-general register
   wire wrSp = wrOk & (regAddr == `CMR_IDX_SP);
   wire wrLr = wrOk & (regAddr == `CMR_IDX_LR);
   wire wrPc = wrOk & (regAddr == `CMR_IDX_PC);
   wire wrPsr = wrOk & (regAddr == `CMR_IDX_PSR);
   wire wrApsr = wrOk & (regAddr == `CMR_IDX_APPLICATION_STATUS);
   wire wrEpsr = wrOk & (regAddr == `CMR_IDX_EXECUTION_STATUS);
   wire wrPrim = wrOk & (regAddr == `CMR_IDX_PRIM);
   wire wrFltm = wrOk & (regAddr == `CMR_IDX_FLTM);
   wire wrBpri = wrOk & (regAddr == `CMR_IDX_BPRI);
   wire wrMode = wrOk & (regAddr == `CMR_IDX_MODE);
   wire wrMsp = wrOk & (regAddr == `CMR_IDX_MSP);
   wire wrPsp = wrOk & (regAddr == `CMR_IDX_PSP);

   // RQ6 RQ7 banked stack pointers
   always @* begin
      msp_nxt = msp_r;
      psp_nxt = psp_r;
      if (wrSp) begin
         if (usePsp) begin
            psp_nxt = spWr;
         end else begin
            msp_nxt = spWr;
         end
      end
      if (wrMsp) begin
         msp_nxt = spWr;
      end
      if (wrPsp) begin
         psp_nxt = spWr;
      end
   end

   // RQ8 link register load
   always @* begin
      lr_nxt = lr_r;
      if (wrLr) begin
         lr_nxt = regWrData;
      end
      // RQ8 call overrides software write
      if (callValid) begin
         lr_nxt = callReturnAddr;
      end
   end

   // RQ9 halfword aligned fetch
   always @* begin
      pc_nxt = pc_r;
      if (wrPc) begin
         pc_nxt = {regWrData[31:1], 1'b0};
      end
   end

   // RQ11 result flags field
   always @* begin
      application_status_nxt = application_status_r;
      if (wrPsr | wrApsr) begin
         application_status_nxt = regWrData & `CMR_APPLICATION_STATUS_MASK;
      end
      // RQ11 execution flags win
      if (flagsValid) begin
         application_status_nxt = {flagsIn, 27'h0000000};
      end
   end

   // RQ13 RQ14 control ranges, bit 24 held
   always @* begin
      execution_status_nxt = execution_status_r;
      if (wrPsr | wrEpsr) begin
         execution_status_nxt = (regWrData & `CMR_EXECUTION_STATUS_MASK) | `CMR_RST_EXECUTION_STATUS;
      end
   end

   // RQ3 RQ12 handler entry and return
   always @* begin
      interrupt_status_nxt = interrupt_status_r;
      if (excEnter) begin
         interrupt_status_nxt = excNum;
      end else if (excReturn) begin
         interrupt_status_nxt = 9'h000;
      end
   end

   // RQ15 primary mask
   always @* begin
      prim_nxt = prim_r;
      if (wrPrim) begin
         prim_nxt = regWrData[0];
      end
   end

   // RQ16 fault mask
   always @* begin
      fltm_nxt = fltm_r;
      if (wrFltm) begin
         fltm_nxt = regWrData[0];
      end
   end

   // RQ17 base priority level
   always @* begin
      bpri_nxt = bpri_r;
      if (wrBpri) begin
         bpri_nxt = regWrData[PRIO_W-1:0];
      end
   end

   // RQ18 RQ19 mode bits; alt bit written as zero in handler
   always @* begin
      mode_nxt = mode_r;
      if (wrMode) begin
         mode_nxt = {regWrData[`CMR_MODE_ALT] & ~inHandler, regWrData[`CMR_MODE_USER]};
      end
   end

   // read capture
   always @* begin
      rdGpr_nxt = regRd & isGpr & ~gprBad;
      // RQ2 refused reads return zero
      rdHold_nxt = 32'h00000000;
      if (regRd & ~userBad) begin
         rdHold_nxt = rdMux;
      end
   end

   // registered read result
   always @* begin
      regRdData_nxt = rdGpr_r ? gprRd : rdHold_r;
   end

   // RQ2 RQ5 RQ14 fault on blocked access
   always @* begin
      faultPulse_nxt = userBad | cisBad | (isGpr & gprBad & (regRd | regWr));
   end

   // RQ15 RQ16 RQ17 gating result
   always @* begin
      irqTaken_nxt = irqReq & gateOk;
   end

   // RQ1 RQ3 mode outputs
   always @* begin
      handlerMode_nxt = inHandler;
      if (excEnter) begin
         handlerMode_nxt = 1'b1;
      end else if (excReturn) begin
         handlerMode_nxt = 1'b0;
      end
      privileged_nxt = excEnter | ~mode_r[`CMR_MODE_USER] | (inHandler & ~excReturn);
   end

   // nrst is the external_reset_n pin after its pad pull-up
   // RQ20 active low reset
   always @(posedge ref_clk) begin
      if (!nrst) begin
         msp_r <= `CMR_RST_WORD;
         psp_r <= `CMR_RST_WORD;
         lr_r <= `CMR_RST_WORD;
         pc_r <= `CMR_RST_WORD;
         application_status_r <= `CMR_RST_WORD;
         execution_status_r <= `CMR_RST_EXECUTION_STATUS;
         interrupt_status_r <= 9'h000;
         prim_r <= 1'b0;
         fltm_r <= 1'b0;
         bpri_r <= {PRIO_W{1'b0}};
         mode_r <= `CMR_RST_MODE;
         rdGpr_r <= 1'b0;
         rdHold_r <= 32'h00000000;
         regRdData <= 32'h00000000;
         faultPulse <= 1'b0;
         handlerMode <= 1'b0;
         privileged <= 1'b1;
         irqTaken <= 1'b0;
      end else begin
         msp_r <= msp_nxt;
         psp_r <= psp_nxt;
         lr_r <= lr_nxt;
         pc_r <= pc_nxt;
         application_status_r <= application_status_nxt;
         execution_status_r <= execution_status_nxt;
         interrupt_status_r <= interrupt_status_nxt;
         prim_r <= prim_nxt;
         fltm_r <= fltm_nxt;
         bpri_r <= bpri_nxt;
         mode_r <= mode_nxt;
         rdGpr_r <= rdGpr_nxt;
         rdHold_r <= rdHold_nxt;
         regRdData <= regRdData_nxt;
         faultPulse <= faultPulse_nxt;
         handlerMode <= handlerMode_nxt;
         privileged <= privileged_nxt;
         irqTaken <= irqTaken_nxt;
      end
   end
endmodule // cmr_core_regs

/* File: verif/cmr_core_regs_monitor.sv */
// checker on the core register block ports
// assumes cmr_core_regs is the bound module
`timescale 1ns/1ps
module cmr_core_regs_monitor (
   input wire ref_clk,
   input wire nrst,
   input wire [4:0] regAddr,
   input wire regWr,
   input wire regRd,
   input wire narrowInsn,
   input wire excEnter,
   input wire [8:0] excNum,
   input wire excReturn,
   input wire irqReq,
   input wire [8:0] irqNum,
   input wire [31:0] regRdData,
   input wire faultPulse,
   input wire handlerMode,
   input wire privileged,
   input wire irqTaken
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_sp_lo; regRd && regAddr == 5'h0D |-> ##2 regRdData[1:0] == 2'h0; endproperty
   a_sp_lo: assert property (p_sp_lo) else $error("sp low bits");
   property p_pc_lo; regRd && regAddr == 5'h0F |-> ##2 !regRdData[0]; endproperty
   a_pc_lo: assert property (p_pc_lo) else $error("pc bit0");
   property p_hnd_priv; handlerMode |-> privileged; endproperty
   a_hnd_priv: assert property (p_hnd_priv) else $error("user handler");
   property p_exc_in; excEnter && excNum != 9'h000 |-> ##[1:2] handlerMode; endproperty
   a_exc_in: assert property (p_exc_in) else $error("no handler");
   property p_exc_out; excReturn |-> ##[1:2] !handlerMode; endproperty
   a_exc_out: assert property (p_exc_out) else $error("stuck handler");
   property p_usr; regWr && regAddr == 5'h14 && !privileged && !handlerMode |=> faultPulse; endproperty
   a_usr: assert property (p_usr) else $error("user write");
   property p_nar; (regRd || regWr) && narrowInsn && regAddr inside {[5'h08:5'h0C]} |=> faultPulse; endproperty
   a_nar: assert property (p_nar) else $error("narrow high");
   property p_nmi; irqReq && irqNum == 9'h002 |=> irqTaken; endproperty
   a_nmi: assert property (p_nmi) else $error("nmi masked");
   c_hnd: cover property (excEnter ##[1:2] handlerMode);
   c_flt: cover property (faultPulse);
   c_irq: cover property (irqTaken);
endmodule // cmr_core_regs_monitor
bind cmr_core_regs cmr_core_regs_monitor cmr_core_regs_monitor_i (.ref_clk, .nrst, .regAddr, .regWr, .regRd,
   .narrowInsn, .excEnter, .excNum, .excReturn, .irqReq, .irqNum, .regRdData, .faultPulse, .handlerMode,
   .privileged, .irqTaken);

/* File: verif/cmr_core_regs_tb.sv */
// self-checking bench for the core register block
// assumes design and monitor compiled first
`timescale 1ns/1ps
module cmr_core_regs_tb;
   logic ref_clk = 0, nrst = 0, regWr = 0, regRd = 0, narrowInsn = 0, callValid = 0, flagsValid = 0;
   logic excEnter = 0, excReturn = 0, irqReq = 0, faultPulse, handlerMode, privileged, irqTaken, flt;
   logic [4:0] regAddr = 0, flagsIn = 0;
   logic [8:0] excNum = 0, irqNum = 0, irqPrio = 0;
   logic [31:0] regWrData = 0, callReturnAddr = 0, regRdData;
   int err_count = 0, checks_done = 0;
   logic [68:0] rows [8] = '{{5'h0C, 32'hA5A5A5A5, 32'hA5A5A5A5}, {5'h0D, 32'h10000007, 32'h10000004},
      {5'h0E, 32'hDEADBEEF, 32'hDEADBEEF}, {5'h0F, 32'h00000101, 32'h00000100},
      {5'h11, 32'hFFFFFFFF, 32'hF8000000}, {5'h13, 32'h07FFFFFF, 32'h0700FC00},
      {5'h16, 32'h0000FFFF, 32'h000001FF}, {5'h1B, 32'hFFFFFFFF, 32'h00000000}};
   cmr_core_regs cmr_core_regs_i (.ref_clk, .nrst, .regAddr, .regWrData, .regWr, .regRd, .narrowInsn,
      .callValid, .callReturnAddr, .flagsValid, .flagsIn, .excEnter, .excNum, .excReturn, .irqReq, .irqNum,
      .irqPrio, .regRdData, .faultPulse, .handlerMode, .privileged, .irqTaken);
   task automatic chk(input string n, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWr <= 1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWr <= 0;
      #1 flt = faultPulse;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      regRd <= 1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 0;
      #1 flt = faultPulse;
      @(posedge ref_clk);
      #1 chk("read", e, regRdData);
   endtask
   task automatic irq(input logic [8:0] n, p, input logic e);
      @(posedge ref_clk);
      irqReq <= 1;
      irqNum <= n;
      irqPrio <= p;
      @(posedge ref_clk);
      irqReq <= 0;
      #1 chk("irq", e, irqTaken);
   endtask
   task automatic pulse(input logic enter);
      @(posedge ref_clk);
      excEnter <= enter;
      excReturn <= !enter;
      @(posedge ref_clk);
      excEnter <= 0;
      excReturn <= 0;
      repeat (2) @(posedge ref_clk);
      #1 chk("hnd", enter, handlerMode);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial forever #4 ref_clk = ~ref_clk;
   initial begin
      #100000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1;
      #1 chk("priv", 1, privileged);
      rd(5'h13, 32'h01000000);
      foreach (rows[i]) begin
         wr(rows[i][68:64], rows[i][63:32]);
         chk("fault", 0, flt);
         rd(rows[i][68:64], rows[i][31:0]);
      end
      wr(5'h13, 32'h0);
      chk("cis", 1, flt);
      @(posedge ref_clk) narrowInsn <= 1;
      wr(5'h09, 32'h1);
      chk("narrow", 1, flt);
      @(posedge ref_clk) narrowInsn <= 0;
      @(posedge ref_clk);
      callValid <= 1;
      callReturnAddr <= 32'h00004321;
      flagsValid <= 1;
      flagsIn <= 5'h15;
      @(posedge ref_clk);
      callValid <= 0;
      flagsValid <= 0;
      rd(5'h0E, 32'h00004321);
      rd(5'h10, 32'hAF00FC00);
      wr(5'h16, 32'h4);
      irq(9'h014, 9'h003, 1);
      irq(9'h014, 9'h004, 0);
      wr(5'h16, 32'h0);
      irq(9'h014, 9'h1FF, 1);
      wr(5'h14, 32'h1);
      irq(9'h014, 9'h000, 0);
      irq(9'h003, 9'h000, 1);
      wr(5'h15, 32'h1);
      irq(9'h003, 9'h000, 0);
      irq(9'h002, 9'h000, 1);
      wr(5'h14, 32'h0);
      wr(5'h15, 32'h0);
      wr(5'h18, 32'h30000000);
      wr(5'h19, 32'h20000000);
      wr(5'h17, 32'h3);
      rd(5'h0D, 32'h20000000);
      chk("priv", 0, privileged);
      wr(5'h14, 32'h1);
      chk("user", 1, flt);
      rd(5'h18, 32'h0);
      chk("user rd", 1, flt);
      excNum <= 9'h00F;
      pulse(1);
      chk("priv", 1, privileged);
      rd(5'h14, 32'h0);
      rd(5'h0D, 32'h30000000);
      rd(5'h12, 32'h0000000F);
      wr(5'h17, 32'h3);
      rd(5'h17, 32'h1);
      wr(5'h17, 32'h0);
      pulse(0);
      @(posedge ref_clk) nrst <= 0;
      @(posedge ref_clk) nrst <= 1;
      rd(5'h14, 32'h0);
      rd(5'h18, 32'h0);
      end_sim();
   end
endmodule // cmr_core_regs_tb
